/* hw/bfl_flash_read.sv */
// burst read, status toggle and erase sequencing for the flash core
//
// Behaviour
// R01: suspend toggle only inside erase-suspended sector
// R02: read strobe or chip select edge advances toggles
// R03: boundary every 128 words, also address zero
// R04: ready with data, or one clock early
// R05: wait code sets first data edge
// R06: wait code resets to 1101, edge thirteen
// R07: address captured on clock edge, latency starts
// R08: other banks read array data while busy
// R09: host reads status twice before deciding
// R10: erase pre-programs region to 00h first
// R11: ready drops during boundary crossing wait
`timescale 1ns/1ps

module bfl_flash_read #(
	parameter int BANK_W       = 2,
	parameter int SECTOR_W     = 8,
	parameter int REGION_WORDS = 16
) (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_b_i,
	// host pins
	input  wire logic                          address_valid_n_i,
	input  wire logic                          ce_n_i,
	input  wire logic                          oe_n_i,
	input  wire logic [bfl_pkg::ADDR_W-1:0]    addr_i,
	output logic      [bfl_pkg::DATA_W-1:0]    data_o,
	output logic                               data_valid_o,
	output logic                               ready_o,
	// configuration load from the command logic
	input  wire logic                          cfg_load_i,
	input  wire logic                          ready_lead_select_i,
	input  wire logic                          wait_field_msb_i,
	input  wire logic                          wait_field_bit2_i,
	input  wire logic                          wait_field_bit1_i,
	input  wire logic                          wait_field_bit0_i,
	// array read port
	output logic      [bfl_pkg::ADDR_W-1:0]    array_addr_o,
	input  wire logic [bfl_pkg::DATA_W-1:0]    array_data_i,
	// operation state
	input  wire logic                          program_busy_i,
	input  wire logic [BANK_W-1:0]             busy_bank_i,
	input  wire logic                          erase_suspended_i,
	input  wire logic [SECTOR_W-1:0]           suspended_sector_i,
	// erase sequencing
	input  wire logic                          erase_start_i,
	input  wire logic [bfl_pkg::ADDR_W-1:0]    erase_base_i,
	output logic                               pgm_req_o,
	output logic      [bfl_pkg::ADDR_W-1:0]    pgm_addr_o,
	output logic      [bfl_pkg::DATA_W-1:0]    pgm_data_o,
	input  wire logic                          pgm_done_i,
	output logic                               erase_req_o,
	input  wire logic                          erase_done_i,
	output logic                               erase_busy_o
);
	localparam int AW   = bfl_pkg::ADDR_W;
	localparam int NPIN = 3;
	localparam logic [AW-1:0] LAST_OFS = AW'(REGION_WORDS - 1);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [NPIN-1:0] pin_s1_r;
	logic [NPIN-1:0] pin_s2_r;
	logic [NPIN-1:0] pin_s3_r;
	logic [NPIN-1:0] pin_r;
	logic [AW-1:0]   addr_s1_r;
	logic [AW-1:0]   addr_s2_r;
	logic [AW-1:0]   addr_s3_r;
	wire  [NPIN-1:0] pin_raw = {oe_n_i, ce_n_i, address_valid_n_i};
	wire  [NPIN-1:0] pin_nxt = (pin_s2_r & ~(pin_s2_r ^ pin_s3_r))
		| (pin_r & (pin_s2_r ^ pin_s3_r));

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pin_s1_r  <= '1;
			pin_s2_r  <= '1;
			pin_s3_r  <= '1;
			pin_r     <= '1;
			addr_s1_r <= '0;
			addr_s2_r <= '0;
			addr_s3_r <= '0;
		end
		else
		begin
			pin_s1_r  <= pin_raw;
			pin_s2_r  <= pin_s1_r;
			pin_s3_r  <= pin_s2_r;
			pin_r     <= pin_nxt;
			addr_s1_r <= addr_i;
			addr_s2_r <= addr_s1_r;
			addr_s3_r <= addr_s2_r;
		end
	end

	wire avd_fall = pin_r[0] & ~pin_nxt[0];
	wire ce_fall  = pin_r[1] & ~pin_nxt[1];
	wire oe_fall  = pin_r[2] & ~pin_nxt[2];
	wire ce_off   = pin_nxt[1];
	wire oe_off   = pin_nxt[2];

	// ------------------------------------------------------------
	// configuration
	// ------------------------------------------------------------
	logic [3:0] wait_code_r;
	logic       lead_r;
	wire  [3:0] wait_code_in = {wait_field_msb_i, wait_field_bit2_i,
		wait_field_bit1_i, wait_field_bit0_i};                  // [R05]

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wait_code_r <= bfl_pkg::WAIT_DEFAULT;               // [R06]
			lead_r      <= 1'b0;
		end
		else if (cfg_load_i)
		begin
			wait_code_r <= wait_code_in;
			lead_r      <= ready_lead_select_i;
		end
	end

	// ------------------------------------------------------------
	// burst engine
	// ------------------------------------------------------------
	bfl_burst_if burst ();

	assign burst.start      = avd_fall & ~ce_off;               // [R07]
	assign burst.stop       = ce_off;
	assign burst.start_addr = addr_s3_r;
	assign burst.first_edge = bfl_pkg::bfl_first_edge(wait_code_r);

	bfl_burst_engine u_engine (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.bus     (burst.eng)
	);

	// ------------------------------------------------------------
	// erase sequencer
	// ------------------------------------------------------------
	bfl_pkg::bfl_erase_type er_state_r;
	logic [AW-1:0]          pgm_addr_r;
	logic [AW-1:0]          er_ofs_r;
	logic                   pgm_req_r;
	logic                   erase_req_r;
	logic                   erase_busy_r;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			er_state_r  <= bfl_pkg::BFL_E_IDLE;
			pgm_addr_r  <= '0;
			er_ofs_r    <= '0;
			pgm_req_r   <= 1'b0;
			erase_req_r <= 1'b0;
			erase_busy_r <= 1'b0;
		end
		else
		begin
			pgm_req_r   <= 1'b0;
			erase_req_r <= 1'b0;
			unique case (er_state_r)
				bfl_pkg::BFL_E_IDLE:
					if (erase_start_i)
					begin
						pgm_addr_r   <= erase_base_i;
						erase_busy_r <= 1'b1;
						er_ofs_r   <= '0;
						er_state_r <= bfl_pkg::BFL_E_PROG;
					end
				bfl_pkg::BFL_E_PROG:
				begin
					pgm_req_r  <= 1'b1;                         // [R10]
					er_state_r <= bfl_pkg::BFL_E_PWAIT;
				end
				bfl_pkg::BFL_E_PWAIT:
					if (pgm_done_i)
					begin
						er_ofs_r   <= er_ofs_r + 1'b1;
						pgm_addr_r <= pgm_addr_r + 1'b1;
						er_state_r <= (er_ofs_r == LAST_OFS)
							? bfl_pkg::BFL_E_ERASE
							: bfl_pkg::BFL_E_PROG;              // [R10]
					end
				bfl_pkg::BFL_E_ERASE:
				begin
					erase_req_r <= 1'b1;                        // [R10]
					er_state_r  <= bfl_pkg::BFL_E_EWAIT;
				end
				bfl_pkg::BFL_E_EWAIT:
					if (erase_done_i)
					begin
						er_state_r   <= bfl_pkg::BFL_E_IDLE;
						erase_busy_r <= 1'b0;
					end
				default:
				begin
					er_state_r   <= bfl_pkg::BFL_E_IDLE;
					erase_busy_r <= 1'b0;
				end
			endcase
		end
	end

	wire er_busy = erase_busy_r;
	wire op_busy = er_busy | program_busy_i;

	// ------------------------------------------------------------
	// status toggles
	// ------------------------------------------------------------
	logic busy_tog_r;
	logic susp_tog_r;
	// one count per read: a strobe fall only while the other is low
	wire  new_read = (oe_fall & ~ce_off)
		| (ce_fall & ~oe_off);                                  // [R02]
	wire  in_busy  = op_busy
		& (burst.addr[AW-1 -: BANK_W] == busy_bank_i);          // [R08]
	wire  in_susp  = erase_suspended_i
		& (burst.addr[AW-1 -: SECTOR_W]
		== suspended_sector_i);                                 // [R01]

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			busy_tog_r <= 1'b0;
			susp_tog_r <= 1'b0;
		end
		else if (new_read)
		begin
			busy_tog_r <= busy_tog_r ^ op_busy;                 // [R02]
			susp_tog_r <= susp_tog_r ^ in_susp;                 // [R01]
		end
	end

	logic [bfl_pkg::DATA_W-1:0] status_word;
	always_comb
	begin
		status_word = '0;
		status_word[bfl_pkg::BUSY_BIT]    = busy_tog_r;
		status_word[bfl_pkg::SUSPEND_BIT] = susp_tog_r;
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	logic [bfl_pkg::DATA_W-1:0] data_r;
	logic                       valid_r;
	logic                       ready_r;
	wire  [bfl_pkg::DATA_W-1:0] read_word = in_busy
		? status_word : array_data_i;                           // [R08]

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			data_r  <= '0;
			valid_r <= 1'b0;
			ready_r <= 1'b0;
		end
		else
		begin
			valid_r <= burst.pre & ~burst.stop;
			ready_r <= (lead_r ? burst.pre_nxt : burst.pre)
				& ~burst.stop;                                  // [R04] [R11]
			if (burst.pre)
				data_r <= read_word;
		end
	end

	assign data_o       = data_r;
	assign data_valid_o = valid_r;
	assign ready_o      = ready_r;
	assign array_addr_o = burst.addr;
	assign pgm_req_o    = pgm_req_r;
	assign pgm_addr_o   = pgm_addr_r;
	assign pgm_data_o   = bfl_pkg::FILL_WORD;                   // [R10]
	assign erase_req_o  = erase_req_r;
	assign erase_busy_o = er_busy;
endmodule

/* hw/bfl_pkg.sv */
// constants, types and helpers shared by the burst read logic
package bfl_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W      = 24;
	localparam int DATA_W      = 16;
	localparam int WAIT_W      = 4;
	localparam int CNT_W       = 5;

	// ------------------------------------------------------------
	// address boundaries
	// ------------------------------------------------------------
	localparam int          ROW_BITS      = 7;
	localparam logic [6:0]  ROW_LAST      = 7'h7F;
	localparam logic [23:0] ADDR_ZERO     = 24'h000000;
	localparam logic [4:0]  CROSS_WAIT    = 5'h02;

	// ------------------------------------------------------------
	// wait-state field
	// ------------------------------------------------------------
	localparam logic [3:0]  WAIT_DEFAULT  = 4'hD;
	localparam logic [3:0]  WAIT_LOW_TOP  = 4'h5;
	localparam logic [3:0]  WAIT_HIGH_LO  = 4'h8;
	localparam logic [3:0]  WAIT_HIGH_TOP = 4'hD;
	localparam logic [3:0]  EDGE_OFFSET   = 4'h2;
	localparam logic [3:0]  EDGE_DEFAULT  = 4'hD;

	// ------------------------------------------------------------
	// status word layout and fill value
	// ------------------------------------------------------------
	localparam int          SUSPEND_BIT   = 2;
	localparam int          BUSY_BIT      = 6;
	localparam logic [15:0] FILL_WORD     = 16'h0000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		BFL_IDLE,
		BFL_LAT,
		BFL_DATA,
		BFL_CROSS
	} bfl_burst_type;

	typedef enum logic [2:0] {
		BFL_E_IDLE,
		BFL_E_PROG,
		BFL_E_PWAIT,
		BFL_E_ERASE,
		BFL_E_EWAIT
	} bfl_erase_type;

	// rising edge after capture on which first data is valid
	function automatic logic [3:0] bfl_first_edge(input logic [3:0] code);
		logic [3:0] e;
		e = EDGE_DEFAULT;
		if (code <= WAIT_LOW_TOP)
			e = code + EDGE_OFFSET;
		else if (code >= WAIT_HIGH_LO && code <= WAIT_HIGH_TOP)
			e = code;
		return e;
	endfunction

endpackage

/* hw/bfl_burst_if.sv */
// carrier between the read control and the burst engine
`timescale 1ns/1ps

interface bfl_burst_if;
	logic                          start;
	logic                          stop;
	logic [bfl_pkg::ADDR_W-1:0]    start_addr;
	logic [3:0]                    first_edge;
	logic                          pre;
	logic                          pre_nxt;
	logic [bfl_pkg::ADDR_W-1:0]    addr;

	modport ctl (
		output start,
		output stop,
		output start_addr,
		output first_edge,
		input  pre,
		input  pre_nxt,
		input  addr
	);

	modport eng (
		input  start,
		input  stop,
		input  start_addr,
		input  first_edge,
		output pre,
		output pre_nxt,
		output addr
	);
endinterface

/* hw/bfl_burst_engine.sv */
// burst latency and row boundary sequencing
`timescale 1ns/1ps

module bfl_burst_engine (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// control side
	bfl_burst_if.eng  bus
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	bfl_pkg::bfl_burst_type     state_r;
	bfl_pkg::bfl_burst_type     state_nxt;
	logic [bfl_pkg::CNT_W-1:0]  cnt_r;
	logic [bfl_pkg::CNT_W-1:0]  cnt_nxt;
	logic [bfl_pkg::CNT_W-1:0]  lat_r;
	logic [bfl_pkg::ADDR_W-1:0] addr_r;
	logic [bfl_pkg::ADDR_W-1:0] addr_nxt;
	logic [bfl_pkg::CNT_W-1:0]  lat_total;
	wire                        row_end;

	// start at address zero counts as a crossing: extra wait up front
	assign lat_total = {1'b0, bus.first_edge}
		+ ((bus.start_addr == bfl_pkg::ADDR_ZERO)
		? bfl_pkg::CROSS_WAIT : '0);                          // [R03]
	assign row_end = (addr_r[bfl_pkg::ROW_BITS-1:0]
		== bfl_pkg::ROW_LAST);                               // [R03]

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 1'b1;
		addr_nxt  = addr_r;
		if (bus.start)
		begin
			// capture edge is edge 0 of the latency count
			state_nxt = bfl_pkg::BFL_LAT;                    // [R07]
			cnt_nxt   = 5'h01;
			addr_nxt  = bus.start_addr;
		end
		else if (bus.stop)
			state_nxt = bfl_pkg::BFL_IDLE;
		else
		begin
			unique case (state_r)
				bfl_pkg::BFL_IDLE:
					cnt_nxt = '0;
				bfl_pkg::BFL_LAT:
					if (cnt_r == lat_r - 1'b1)
						state_nxt = bfl_pkg::BFL_DATA;       // [R05]
				bfl_pkg::BFL_DATA:
				begin
					addr_nxt = addr_r + 1'b1;
					cnt_nxt  = '0;
					if (row_end)
						state_nxt = bfl_pkg::BFL_CROSS;      // [R11]
				end
				bfl_pkg::BFL_CROSS:
					if (cnt_r == bfl_pkg::CROSS_WAIT - 1'b1)
						state_nxt = bfl_pkg::BFL_DATA;       // [R11]
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_r <= bfl_pkg::BFL_IDLE;
			cnt_r   <= '0;
			lat_r   <= '0;
			addr_r  <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			addr_r  <= addr_nxt;
			if (bus.start)
				lat_r <= lat_total;
		end
	end

	assign bus.pre     = (state_r == bfl_pkg::BFL_DATA);
	assign bus.pre_nxt = (state_nxt == bfl_pkg::BFL_DATA);
	assign bus.addr    = addr_r;
endmodule

/* test/bfl_flash_read_sva.sv */
// assertions on the burst read and erase ports
`timescale 1ns/1ps

module bfl_flash_read_sva #(
	parameter int REGION_WORDS = 16
) (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// burst side
	input wire logic        cfg_load_i,
	input wire logic        ready_lead_select_i,
	input wire logic        data_valid_o,
	input wire logic        ready_o,
	// erase side
	input wire logic        erase_start_i,
	input wire logic [23:0] erase_base_i,
	input wire logic        pgm_req_o,
	input wire logic [23:0] pgm_addr_o,
	input wire logic [15:0] pgm_data_o,
	input wire logic        pgm_done_i,
	input wire logic        erase_req_o,
	input wire logic        erase_busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	logic        lead_r;
	logic [23:0] base_r;
	int          cnt_r;

	// tracks the lead setting and words programmed since the start
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			lead_r <= 1'b0;
			base_r <= 24'h000000;
			cnt_r  <= 0;
		end
		else
		begin
			if (cfg_load_i)
				lead_r <= ready_lead_select_i;
			if (erase_start_i && !erase_busy_o)
			begin
				base_r <= erase_base_i;
				cnt_r  <= 0;
			end
			else if (pgm_req_o)
				cnt_r <= cnt_r + 1;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_start;
		erase_start_i && !erase_busy_o;
	endsequence

	sequence s_last_done;
		pgm_done_i && erase_busy_o && cnt_r == REGION_WORDS;
	endsequence

	fill_zero_a: assert property (pgm_req_o |-> pgm_data_o == 16'h0000)
		else $error("program word not zero");
	erase_busy_a: assert property (s_start |=> erase_busy_o)
		else $error("erase start not taken");
	first_pgm_a: assert property (s_start |=> ##[0:3] pgm_req_o)
		else $error("no first program request");
	pgm_addr_a: assert property (pgm_req_o |->
		pgm_addr_o == base_r + 24'(cnt_r))
		else $error("program address wrong");
	next_pgm_a: assert property (pgm_done_i && erase_busy_o &&
		cnt_r < REGION_WORDS |-> ##[1:4] pgm_req_o)
		else $error("next program request missing");
	erase_after_a: assert property (erase_req_o |->
		cnt_r == REGION_WORDS)
		else $error("erase before all words programmed");
	erase_issue_a: assert property (s_last_done |->
		##[1:4] erase_req_o)
		else $error("erase request missing");
	ready_gap_a: assert property (!lead_r && !data_valid_o |->
		!ready_o)
		else $error("ready high without data");
	lead_same_a: assert property (!lead_r && data_valid_o |-> ready_o)
		else $error("ready not with data");
	lead_early_a: assert property (lead_r && $rose(data_valid_o) |->
		$past(ready_o))
		else $error("ready not one clock early");
endmodule

/* test/bfl_host_model.sv */
// host controller model driving the strobes and the muxed address
`timescale 1ns/1ps

module bfl_host_model (
	// clock
	input  wire logic   clk_i,
	// host pins
	output logic        address_valid_n_o,
	output logic        ce_n_o,
	output logic        oe_n_o,
	output logic [23:0] addr_o
);
	initial
	begin
		{address_valid_n_o, ce_n_o, oe_n_o} = 3'h7;
		addr_o = 24'h5A5A5A;
	end

	// strobe held four edges so the pin filter sees it, then read
	task automatic start(input logic [23:0] a);
		@(posedge clk_i);
		ce_n_o <= 1'b0;
		address_valid_n_o <= 1'b0;
		addr_o <= a;
		repeat (4) @(posedge clk_i);
		address_valid_n_o <= 1'b1;
		oe_n_o <= 1'b0;
		addr_o <= ~a;
	endtask

	// deselect and let the synchronisers settle
	task automatic stop();
		@(posedge clk_i);
		{ce_n_o, oe_n_o} <= 2'h3;
		addr_o <= ~addr_o;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

/* test/burst_flash_latency_status_test.sv */
// self-checking bench for the burst read, status and erase logic
`timescale 1ns/1ps

module burst_flash_latency_status_test;
	logic        clk_i, rst_b_i, cfg_ld, lead, pbusy, esusp, estart;
	logic        pdone, edone, dv, rdy, preq, ereq, ebusy, avn, cen, oen;
	logic [3:0]  code;
	logic [1:0]  bbank;
	logic [7:0]  ssec;
	logic [23:0] addr, aaddr, ebase, paddr;
	logic [15:0] dout, pdata, adata, q_d[$];
	int          bad_count, check_count, cyc, n_pgm, n_ers, q_t[$];

	assign adata = aaddr[15:0] ^ 16'hA5C3;

	bfl_host_model u_host (.clk_i(clk_i), .address_valid_n_o(avn),
		.ce_n_o(cen), .oe_n_o(oen), .addr_o(addr));

	bfl_flash_read u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.address_valid_n_i(avn), .ce_n_i(cen), .oe_n_i(oen),
		.addr_i(addr), .data_o(dout), .data_valid_o(dv), .ready_o(rdy),
		.cfg_load_i(cfg_ld), .ready_lead_select_i(lead),
		.wait_field_msb_i(code[3]), .wait_field_bit2_i(code[2]),
		.wait_field_bit1_i(code[1]), .wait_field_bit0_i(code[0]),
		.array_addr_o(aaddr), .array_data_i(adata),
		.program_busy_i(pbusy), .busy_bank_i(bbank),
		.erase_suspended_i(esusp), .suspended_sector_i(ssec),
		.erase_start_i(estart), .erase_base_i(ebase), .pgm_req_o(preq),
		.pgm_addr_o(paddr), .pgm_data_o(pdata), .pgm_done_i(pdone),
		.erase_req_o(ereq), .erase_done_i(edone), .erase_busy_o(ebusy));

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// answers the erase sequencer promptly and logs burst words
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		pdone <= preq;
		edone <= ereq;
		n_pgm <= n_pgm + int'(preq);
		n_ers <= n_ers + int'(ereq);
		if (dv)
		begin
			q_d.push_back(dout);
			q_t.push_back(cyc);
		end
	end

	// ------------------------------------------------------------
	// expectations, compares and bus tasks
	// ------------------------------------------------------------
	function automatic int n_edge(input logic [3:0] c);
		if (c <= 4'h5)
			return c + 2;
		if (c >= 4'h8 && c <= 4'hD)
			return c;
		return 13;
	endfunction

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkint(input int got, input int exp);
		check_count++;
		if (got != exp)
		begin
			bad_count++;
			$display("ERROR %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic set_cfg(input logic [3:0] c, input logic l);
		@(posedge clk_i);
		code <= c;
		lead <= l;
		cfg_ld <= 1'b1;
		@(posedge clk_i);
		cfg_ld <= 1'b0;
	endtask

	task automatic burst(input logic [23:0] a, input int n, input bit arr,
		output int lat);
		int t0;
		q_d.delete();
		q_t.delete();
		@(negedge clk_i);
		t0 = cyc;
		u_host.start(a);
		for (int k = 0; k < 200 && q_d.size() < n; k++)
			@(negedge clk_i);
		u_host.stop();
		chkint(q_d.size() >= n, 1);
		lat = (q_t.size() > 0) ? q_t[0] - t0 : -1;
		for (int i = 0; arr && i < n && i < q_d.size(); i++)
		begin
			chk16(q_d[i], 16'(a + i) ^ 16'hA5C3);
			if (i > 0)
				chkint(q_t[i] - q_t[i-1],
					(7'(a + i - 1) == 7'h7F) ? 3 : 1);
		end
	endtask

	// two reads in a row; their difference shows which bits toggle
	task automatic st(input logic [23:0] a, input logic [15:0] m);
		int l;
		logic [15:0] s1;
		burst(a, 1, 1'b0, l);
		s1 = q_d[0];
		burst(a, 1, 1'b0, l);
		chk16(s1 ^ q_d[0], m);
		chk16(s1 & ~16'h0044, 16'h0000);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		int lat;
		int base;
		int ld;
		rst_b_i = 1'b0;
		{cfg_ld, lead, pbusy, esusp, estart, pdone, edone} = 7'h00;
		{code, bbank, ssec, ebase} = 38'h0;
		{cyc, n_pgm, n_ers, bad_count, check_count} = '0;
		void'($urandom(23));
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		burst(24'h000345, 2, 1'b1, ld);
		set_cfg(4'h0, 1'b0);
		burst(24'h000345, 2, 1'b1, lat);
		base = lat - 2;
		chkint(ld - base, 13);
		for (int c = 0; c < 16; c++)
		begin
			set_cfg(4'(c), 1'($urandom));
			burst(24'($urandom) & 24'h00FFFF | 24'h1, 4, 1'b1, lat);
			chkint(lat - base, n_edge(4'(c)));
		end
		set_cfg(4'h2, 1'b1);
		burst(24'h00017D, 5, 1'b1, lat);
		burst(24'h000000, 3, 1'b1, lat);
		chkint(lat - base, 6);
		bbank <= 2'h2;
		ssec <= 8'h85;
		esusp <= 1'b1;
		pbusy <= 1'b1;
		st(24'h850010, 16'h0044);
		st(24'h860010, 16'h0040);
		burst(24'h120033, 2, 1'b1, lat);
		pbusy <= 1'b0;
		esusp <= 1'b0;
		ebase <= 24'($urandom) & 24'hFFFFF0;
		estart <= 1'b1;
		@(posedge clk_i);
		estart <= 1'b0;
		repeat (5) @(posedge clk_i);
		estart <= 1'b1;
		@(posedge clk_i);
		estart <= 1'b0;
		for (int k = 0; k < 500 && ebusy !== 1'b0; k++)
			@(posedge clk_i);
		repeat (2) @(posedge clk_i);
		chkint(n_pgm, 16);
		chkint(n_ers, 1);
		wrap_up();
	end

	initial
	begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		wrap_up();
	end
endmodule

bind bfl_flash_read bfl_flash_read_sva #(.REGION_WORDS(REGION_WORDS)) u_sva (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_load_i(cfg_load_i),
	.ready_lead_select_i(ready_lead_select_i), .data_valid_o(data_valid_o),
	.ready_o(ready_o), .erase_start_i(erase_start_i),
	.erase_base_i(erase_base_i), .pgm_req_o(pgm_req_o),
	.pgm_addr_o(pgm_addr_o), .pgm_data_o(pgm_data_o),
	.pgm_done_i(pgm_done_i), .erase_req_o(erase_req_o),
	.erase_busy_o(erase_busy_o));
